// ===== cbf_pkg.sv
// Package of constants and carrier types for the command buffer state machine.
package cbf_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    localparam int unsigned TIMEOUT_B_US      = 750;
    localparam int unsigned TIMEOUT_B_CYCLES  = (TIMEOUT_B_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned INIT_CYCLES       = 16;

    // ----------------------------------------------------------------
    // Buffer and interrupt layout
    // ----------------------------------------------------------------
    localparam int unsigned BUF_DEPTH         = 64;
    localparam int unsigned BUF_ADDR_W        = 6;
    localparam int unsigned IRQ_CAUSES        = 4;
    localparam int unsigned IRQ_START_DONE    = 0;
    localparam int unsigned IRQ_CANCEL_DONE   = 1;
    localparam int unsigned IRQ_READY         = 2;
    localparam int unsigned IRQ_IDLE          = 3;
    localparam logic [3:0]  IRQ_STATUS_RESET  = 4'h0;

    typedef enum logic [2:0] {
        CBF_INIT,
        CBF_IDLE,
        CBF_READY,
        CBF_RECEPTION,
        CBF_EXECUTION,
        CBF_COMPLETION
    } cbf_state_e;

    // One host write to the control area; each bit is a one-cycle strobe.
    typedef struct packed {
        logic request_ready_bit_full;
        logic request_go_idle_full;
        logic start_register;
        logic cancel_field;
    } cbf_ctrl_wr_s;

    // Host access to the command/response buffer.
    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [BUF_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
    } cbf_buf_req_s;

    // Control area as seen by host reads.
    typedef struct packed {
        logic request_ready_bit_full;
        logic request_go_idle_full;
        logic status_idle_full;
        logic status_error_full;
        logic start_register;
        logic cancel_register;
    } cbf_ctrl_view_s;

endpackage : cbf_pkg

// ===== cbf_buffer_mem.sv
// Byte memory holding the command and response, with registered read data.
`timescale 1ns/100ps
module cbf_buffer_mem
    import cbf_pkg::*;
#(
    parameter int unsigned DEPTH  = BUF_DEPTH,
    parameter int unsigned ADDR_W = BUF_ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [7:0]        rdata
);

    if (DEPTH == 0 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
        $error("Buffer depth is zero or exceeds address range.");
    end

    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule : cbf_buffer_mem

// ===== cbf_cmd_buffer.sv
// Command/response buffer state machine with interrupt status and acknowledge gating.
`timescale 1ns/100ps

// Functional notes
// R1: Control shows ready, go-idle, idle, error, start, cancel.
// R2: Reach Idle with idle flag within TIMEOUT_B.
// R3: Start in Reception enters Execution, start held.
// R4: Go-idle in Reception aborts, returns Idle.
// R5: Start writes in Execution ignored, start stays.
// R6: Ready or go-idle in Execution ignored.
// R7: Command done clears start, enters Completion.
// R8: Cancel in Execution: Completion, clear start, cancel.
// R9: Buffer accesses ignored during Execution.
// R10: Ready in Completion ignored unless bypass set.
// R11: Go-idle in Completion: Idle, invalidate buffer.
// R12: Start or cancel in Completion ignored.
// R13: Sequential reads return successive response bytes.
// R14: Non-sequential reads in Completion ignored.
// R15: Base address read restarts response delivery.
// R16: Events always set their status cause bit.
// R17: Rising status bit asserts interrupt if none outstanding.
// R18: No new interrupt until acknowledge write.
// R19: Acknowledge clears every status bit written one.
// R20: Host reads cause, acknowledges controller, then device.
// R21: Host may clear several causes together.
// R22: Reset clears status, latch; state goes Init.
module cbf_cmd_buffer
    import cbf_pkg::*;
#(
    parameter int unsigned TIMEOUT_B_CYC = TIMEOUT_B_CYCLES,
    parameter int unsigned INIT_CYC      = INIT_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire cbf_ctrl_wr_s          ctrl_wr,
    input  wire cbf_buf_req_s          buf_req,
    input  wire logic                  idle_bypass_capability,
    input  wire logic                  cmd_done,
    input  wire logic                  irq_ack_wr,
    input  wire logic [IRQ_CAUSES-1:0] irq_ack_data,
    output cbf_ctrl_view_s             ctrl_view,
    output logic [7:0]                 buf_rdata,
    output logic                       buf_rvalid,
    output logic                       cmd_go,
    output logic                       cmd_abort,
    output logic [BUF_ADDR_W-1:0]      cmd_length,
    output logic [IRQ_CAUSES-1:0]      buffer_irq_status,
    output logic                       irq_out,
    output logic                       irq_outstanding,
    output logic                       timeout_b_miss
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (INIT_CYC == 0 || INIT_CYC >= TIMEOUT_B_CYC) begin : g_bad_init
        $error("Init time must be nonzero and below TIMEOUT_B.");
    end

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    cbf_state_e            state;
    cbf_state_e            next_state;
    logic [31:0]           tmo_cnt;
    logic [BUF_ADDR_W-1:0] rd_ptr;
    logic                  buf_valid;
    logic                  ev_done;
    logic                  ev_cancel;
    logic                  ev_ready;
    logic                  ev_idle;

    always_comb begin
        next_state = state;
        ev_done    = 1'b0;
        ev_cancel  = 1'b0;
        ev_ready   = 1'b0;
        ev_idle    = 1'b0;
        unique case (state)
            CBF_INIT: begin
                if (tmo_cnt >= 32'(INIT_CYC)) begin
                    next_state = CBF_IDLE; // R2
                    ev_idle    = 1'b1;
                end
            end
            CBF_IDLE: begin
                if (ctrl_wr.request_ready_bit_full && !ctrl_wr.request_go_idle_full) begin
                    next_state = CBF_READY;
                    ev_ready   = 1'b1;
                end
            end
            CBF_READY: begin
                if (ctrl_wr.request_go_idle_full) begin
                    next_state = CBF_IDLE;
                    ev_idle    = 1'b1;
                end else if (buf_req.wr) begin
                    next_state = CBF_RECEPTION;
                end
            end
            CBF_RECEPTION: begin
                if (ctrl_wr.request_go_idle_full) begin
                    next_state = CBF_IDLE; // R4
                    ev_idle    = 1'b1;
                end else if (ctrl_wr.request_ready_bit_full) begin
                    next_state = CBF_READY;
                end else if (ctrl_wr.start_register) begin
                    next_state = CBF_EXECUTION; // R3
                end
            end
            CBF_EXECUTION: begin // R6
                // Ready, go-idle, start and buffer accesses fall through here.
                if (ctrl_wr.cancel_field) begin
                    next_state = CBF_COMPLETION; // R8
                    ev_cancel  = 1'b1;
                end else if (cmd_done) begin
                    next_state = CBF_COMPLETION; // R7
                    ev_done    = 1'b1;
                end
            end
            CBF_COMPLETION: begin
                if (ctrl_wr.request_go_idle_full) begin
                    next_state = CBF_IDLE; // R11
                    ev_idle    = 1'b1;
                end else if (ctrl_wr.request_ready_bit_full && idle_bypass_capability) begin
                    next_state = CBF_READY; // R10
                    ev_ready   = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CBF_INIT; // R22
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Time in state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmo_cnt        <= 32'h0;
            timeout_b_miss <= 1'b0;
        end else begin
            if (next_state != state) begin
                tmo_cnt <= 32'h0;
            end else if (tmo_cnt != 32'hffffffff) begin
                tmo_cnt <= tmo_cnt + 32'h1;
            end
            if (state == CBF_INIT && tmo_cnt >= 32'(TIMEOUT_B_CYC)) begin
                timeout_b_miss <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control area view
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_view <= '0;
        end else begin
            ctrl_view.request_ready_bit_full <= 1'b0; // R1
            ctrl_view.request_go_idle_full   <= 1'b0;
            ctrl_view.status_idle_full       <= (next_state == CBF_IDLE); // R2 R4 R11
            ctrl_view.status_error_full      <= 1'b0;
            ctrl_view.start_register         <= (next_state == CBF_EXECUTION); // R5 R7 R8
            ctrl_view.cancel_register        <= 1'b0; // R8 R12
        end
    end

    // ----------------------------------------------------------------
    // Command engine handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_go    <= 1'b0;
            cmd_abort <= 1'b0;
        end else begin
            cmd_go    <= (state == CBF_RECEPTION) && (next_state == CBF_EXECUTION); // R3
            cmd_abort <= ev_cancel; // R8
        end
    end

    // ----------------------------------------------------------------
    // Buffer access
    // ----------------------------------------------------------------
    logic                  mem_we;
    logic                  rd_accept;
    logic [BUF_ADDR_W-1:0] mem_raddr;
    logic [7:0]            mem_rdata;

    // Writes land only while receiving a command.
    assign mem_we    = buf_req.wr && (state == CBF_READY || state == CBF_RECEPTION); // R9
    assign rd_accept = buf_req.rd && state == CBF_COMPLETION && buf_valid
                       && (buf_req.addr == rd_ptr || buf_req.addr == '0); // R13 R14 R15
    assign mem_raddr = buf_req.addr;

    // The length is the last written byte address plus one, so the first write counts too.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_length <= '0;
        end else if (ev_idle || ev_ready) begin
            cmd_length <= '0;
        end else if (mem_we) begin
            cmd_length <= buf_req.addr + BUF_ADDR_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr    <= '0;
            buf_valid <= 1'b0;
        end else begin
            if (ev_done || ev_cancel) begin
                buf_valid <= 1'b1;
                rd_ptr    <= '0;
            end else if (ev_idle || ev_ready) begin
                buf_valid <= 1'b0; // R11
            end else if (rd_accept) begin
                rd_ptr <= buf_req.addr + BUF_ADDR_W'(1); // R13 R15
            end
        end
    end

    cbf_buffer_mem #(
        .DEPTH  (BUF_DEPTH),
        .ADDR_W (BUF_ADDR_W)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (buf_req.addr),
        .wdata (buf_req.wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic rd_accept_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_accept_q <= 1'b0;
        end else begin
            rd_accept_q <= rd_accept;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_rdata  <= 8'h00;
            buf_rvalid <= 1'b0;
        end else begin
            buf_rvalid <= rd_accept_q;
            buf_rdata  <= rd_accept_q ? mem_rdata : 8'h00; // R13
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status and gating
    // ----------------------------------------------------------------
    logic [IRQ_CAUSES-1:0] irq_set;
    logic [IRQ_CAUSES-1:0] next_status;

    always_comb begin
        irq_set                  = '0;
        irq_set[IRQ_START_DONE]  = ev_done;
        irq_set[IRQ_CANCEL_DONE] = ev_cancel;
        irq_set[IRQ_READY]       = ev_ready;
        irq_set[IRQ_IDLE]        = ev_idle;
        // Set wins over a clear in the same cycle.
        next_status = (buffer_irq_status & ~(irq_ack_wr ? irq_ack_data : '0)) | irq_set; // R16 R19
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buffer_irq_status <= IRQ_STATUS_RESET; // R22
        end else begin
            buffer_irq_status <= next_status; // R16 R19 R21
        end
    end

    // ----------------------------------------------------------------
    // Interrupt line
    // ----------------------------------------------------------------
    // The line goes high on a fresh cause while no interrupt is outstanding,
    // and again after an acknowledge that leaves causes set.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_outstanding <= 1'b0; // R22
            irq_out         <= 1'b0;
        end else if (irq_outstanding) begin
            if (irq_ack_wr) begin
                irq_outstanding <= 1'b0; // R18 R20
                irq_out         <= 1'b0;
            end
        end else if ((|(irq_set & ~buffer_irq_status)) || (|buffer_irq_status && !irq_ack_wr)) begin
            irq_outstanding <= 1'b1; // R17
            irq_out         <= 1'b1;
        end
    end

endmodule : cbf_cmd_buffer

// ===== cbf_cmd_buffer_sva.sv
// Checker of the command buffer state machine and its interrupt gating.
`timescale 1ns/100ps
module cbf_cmd_buffer_chk
    import cbf_pkg::*;
#(
    parameter int unsigned TIMEOUT_B_CYC = TIMEOUT_B_CYCLES,
    parameter int unsigned INIT_CYC      = INIT_CYCLES
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire cbf_ctrl_wr_s          ctrl_wr,
    input wire cbf_buf_req_s          buf_req,
    input wire logic                  cmd_done,
    input wire logic                  irq_ack_wr,
    input wire logic [IRQ_CAUSES-1:0] irq_ack_data,
    input wire cbf_ctrl_view_s        ctrl_view,
    input wire logic                  buf_rvalid,
    input wire logic                  cmd_go,
    input wire logic                  cmd_abort,
    input wire logic [IRQ_CAUSES-1:0] buffer_irq_status,
    input wire logic                  irq_out
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    logic st;
    assign st = ctrl_view.start_register;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_go_start: assert property (cmd_go |-> st && !ctrl_view.status_idle_full)
        else $error("start not shown with command go");
    chk_start_hold: assert property (st && !cmd_done && !ctrl_wr.cancel_field |=> st)
        else $error("start dropped during execution");
    chk_done_clear: assert property (st && cmd_done
        |=> !st && (buffer_irq_status[IRQ_START_DONE] || buffer_irq_status[IRQ_CANCEL_DONE]))
        else $error("completion did not clear start");
    chk_cancel_end: assert property (st && ctrl_wr.cancel_field
        |=> !st && cmd_abort && buffer_irq_status[IRQ_CANCEL_DONE])
        else $error("cancel not handled");
    chk_go_idle: assert property (ctrl_wr.request_go_idle_full && !st && !ctrl_view.status_idle_full
        |=> ctrl_view.status_idle_full)
        else $error("go idle did not reach idle");
    chk_irq_rise: assert property ((buffer_irq_status & ~$past(buffer_irq_status)) != 4'h0
        && !$past(irq_out) |-> ##[0:1] irq_out)
        else $error("interrupt not raised");
    chk_irq_hold: assert property (irq_out && !irq_ack_wr |=> irq_out)
        else $error("interrupt dropped without acknowledge");
    chk_ack_drop: assert property (irq_ack_wr && irq_out |=> !irq_out)
        else $error("acknowledge did not end interrupt");
    chk_ack_clear: assert property (irq_ack_wr && !cmd_done && ctrl_wr == '0
        |=> (buffer_irq_status & $past(irq_ack_data)) == 4'h0)
        else $error("acknowledged cause not cleared");
    chk_re_raise: assert property (irq_ack_wr ##1 buffer_irq_status != 4'h0 |=> irq_out)
        else $error("no new interrupt for remaining causes");
    chk_rd_lat: assert property (buf_rvalid |-> $past(buf_req.rd, 2))
        else $error("read data without read");
    chk_exec_rd: assert property (st && buf_req.rd |-> ##2 !buf_rvalid)
        else $error("read answered during execution");
endmodule : cbf_cmd_buffer_chk

bind cbf_cmd_buffer cbf_cmd_buffer_chk #(.TIMEOUT_B_CYC(TIMEOUT_B_CYC), .INIT_CYC(INIT_CYC)) chk_u (.clk, .rst,
    .ctrl_wr, .buf_req, .cmd_done, .irq_ack_wr, .irq_ack_data, .ctrl_view, .buf_rvalid, .cmd_go, .cmd_abort,
    .buffer_irq_status, .irq_out);

// ===== cbf_engine_model.sv
// Command engine model that finishes a started command after a set delay.
`timescale 1ns/100ps
module cbf_engine_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       abort,
    input  wire logic [7:0] delay,
    output logic            done
);
    // ----------------------------------------------------------------
    // Command timing
    // ----------------------------------------------------------------
    logic       busy;
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt  <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go) begin
                busy <= 1'b1;
                cnt  <= delay;
            end else if (abort) begin
                busy <= 1'b0;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                done <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : cbf_engine_model

// ===== cbf_cmd_buffer_test.sv
// Self-checking testbench of the command buffer state machine.
`timescale 1ns/100ps
module cbf_cmd_buffer_test
    import cbf_pkg::*;
();
    // ----------------------------------------------------------------
    // Bench
    // ----------------------------------------------------------------
    logic                  clk, rst, bypass, ack_wr, done, go, abrt, rv, irq, outst, miss;
    logic [3:0]            ack_d, sts;
    logic [7:0]            rd, dly;
    logic [BUF_ADDR_W-1:0] len;
    cbf_ctrl_wr_s          cw;
    cbf_buf_req_s          br;
    cbf_ctrl_view_s        cv;
    int                    err_total, n_tests;

    cbf_cmd_buffer #(.TIMEOUT_B_CYC(64), .INIT_CYC(4)) dut_u (.clk(clk), .rst(rst), .ctrl_wr(cw), .buf_req(br),
        .idle_bypass_capability(bypass), .cmd_done(done), .irq_ack_wr(ack_wr), .irq_ack_data(ack_d),
        .ctrl_view(cv), .buf_rdata(rd), .buf_rvalid(rv), .cmd_go(go), .cmd_abort(abrt), .cmd_length(len),
        .buffer_irq_status(sts), .irq_out(irq), .irq_outstanding(outst), .timeout_b_miss(miss));
    cbf_engine_model eng_u (.clk(clk), .rst(rst), .go(go), .abort(abrt), .delay(dly), .done(done));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] v);
        @(posedge clk);
        cw <= cbf_ctrl_wr_s'(v);
        @(posedge clk);
        cw <= '0;
        #1;
    endtask : wr
    task automatic ack(input logic [3:0] d);
        @(posedge clk);
        ack_wr <= 1'b1;
        ack_d  <= d;
        @(posedge clk);
        ack_wr <= 1'b0;
        #1;
    endtask : ack
    task automatic bwr(input logic [BUF_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        br <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        br <= '0;
    endtask : bwr
    task automatic brd(input logic [BUF_ADDR_W-1:0] a, input logic v, input logic [7:0] d);
        logic       seen;
        logic [7:0] got;
        seen = 1'b0;
        got  = 8'h00;
        @(posedge clk);
        br <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        br <= '0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            if (rv === 1'b1) begin
                seen = 1'b1;
                got  = rd;
            end
        end
        chk(seen, v);
        if (v) chk(got, d);
    endtask : brd
    task automatic wait_cv(input int b, input logic v, input int lim);
        logic [5:0] c;
        for (int i = 0; i < lim; i++) begin
            c = cv;
            if (c[b] === v) return;
            @(posedge clk);
            #1;
        end
        err_total++;
        results();
    endtask : wait_cv

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst       = 1'b1;
        cw        = '0;
        br        = '0;
        bypass    = 1'b0;
        ack_wr    = 1'b0;
        ack_d     = 4'h0;
        dly       = 8'h28;
        err_total = 0;
        n_tests   = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(sts, 4'h0);
        chk(cv.status_idle_full, 1'b0);
        wait_cv(3, 1'b1, 40);
        @(posedge clk);
        #1;
        chk(sts, 4'h8);
        chk({2'b00, cv}, 8'h08);
        chk(irq, 1'b1);
        chk(outst, 1'b1);
        chk(miss, 1'b0);
        ack(4'h8);
        chk(irq, 1'b0);
        chk(outst, 1'b0);
        chk(sts, 4'h0);
        $display("test reset done");
        wr(4'h8);
        chk(sts, 4'h4);
        bwr(6'h00, 8'ha5);
        wr(4'h4);
        chk(cv.status_idle_full, 1'b1);
        chk(sts, 4'hc);
        ack(4'h4);
        chk(irq, 1'b0);
        @(posedge clk);
        #1;
        chk(irq, 1'b1);
        chk(sts, 4'h8);
        ack(4'h8);
        $display("test abort reception done");
        wr(4'h8);
        ack(4'h4);
        for (int i = 0; i < 4; i++) bwr(6'(i), 8'h30 + 8'(i));
        wr(4'h2);
        chk(go, 1'b1);
        chk(cv.start_register, 1'b1);
        chk(len, 6'h04);
        wr(4'h2);
        wr(4'h8);
        wr(4'h4);
        bwr(6'h00, 8'hff);
        brd(6'h00, 1'b0, 8'h00);
        chk(cv.start_register, 1'b1);
        chk(cv.status_idle_full, 1'b0);
        wait_cv(1, 1'b0, 60);
        chk(sts, 4'h1);
        ack(4'h1);
        wr(4'h2);
        wr(4'h1);
        chk(cv.start_register, 1'b0);
        chk(abrt, 1'b0);
        wr(4'h8);
        chk(sts, 4'h0);
        brd(6'h00, 1'b1, 8'h30);
        brd(6'h01, 1'b1, 8'h31);
        brd(6'h03, 1'b0, 8'h00);
        brd(6'h02, 1'b1, 8'h32);
        brd(6'h00, 1'b1, 8'h30);
        brd(6'h01, 1'b1, 8'h31);
        @(posedge clk);
        bypass <= 1'b1;
        dly    <= 8'hc8;
        wr(4'h8);
        chk(sts, 4'h4);
        brd(6'h00, 1'b0, 8'h00);
        ack(4'h4);
        $display("test execution and completion done");
        bwr(6'h00, 8'h55);
        wr(4'h2);
        chk(len, 6'h01);
        wr(4'h1);
        chk(cv.start_register, 1'b0);
        chk(abrt, 1'b1);
        chk(sts, 4'h2);
        wr(4'h4);
        chk(cv.status_idle_full, 1'b1);
        chk(sts, 4'ha);
        ack(4'ha);
        chk(sts, 4'h0);
        $display("test cancel done");
        results();
    end
endmodule : cbf_cmd_buffer_test
